//--- rtl/etac_pkg.sv
// Constants and types shared by the acquisition control sequencer
package etac_pkg;
  // Trigger source select encodings
  localparam logic [2:0] ETAC_SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] ETAC_SRC_USER_OUT = 3'h1;
  localparam logic [2:0] ETAC_SRC_LINK = 3'h2;
  localparam logic [2:0] ETAC_SRC_TIMER = 3'h3;
  localparam logic [2:0] ETAC_SRC_LINE = 3'h4;
  // Setting widths
  localparam int ETAC_CNT_W = 24;
  localparam int ETAC_RD_W = 24;
  // Reset value and increment of counters
  localparam logic [ETAC_CNT_W-1:0] ETAC_CNT_ZERO = 24'h00_0000;
  localparam logic [ETAC_CNT_W-1:0] ETAC_CNT_ONE = 24'h00_0001;
  // Clock rate and derived clock period in nanoseconds
  localparam int ETAC_CLK_HZ = 50_000_000;
  localparam int ETAC_CLK_NS = 1_000_000_000 / ETAC_CLK_HZ;
  // Sequencer states
  typedef enum logic [2:0] {
    ETAC_IDLE,
    ETAC_WAIT,
    ETAC_EXPOSE,
    ETAC_READOUT,
    ETAC_RECOVER
  } etac_state_t;
endpackage

//--- rtl/etac_edge_sync.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module etac_edge_sync
  import etac_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Synchroniser chain; the first stage feeds only the second
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge pulses from the synchronised level
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

//--- rtl/etac_period_timer.sv
// Free-run period generator clamped to a minimum period
`timescale 1ns/1ps
`default_nettype none
module etac_period_timer
  import etac_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [ETAC_CNT_W-1:0] period_cycles,
  input wire logic [ETAC_CNT_W-1:0] min_period_cycles,
  output logic tick
);
  logic [ETAC_CNT_W-1:0] count_q;
  logic [ETAC_CNT_W-1:0] limit;

  // Programmed period never shorter than the fastest allowed period
  assign limit = (period_cycles < min_period_cycles) ?
    min_period_cycles : period_cycles;

  // Counts while running; restarts at zero when stopped
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      count_q <= ETAC_CNT_ZERO;
    else if (!run || tick)
      count_q <= ETAC_CNT_ZERO;
    else
      count_q <= count_q + ETAC_CNT_ONE;
  end

  // Tick when the period elapses; first tick one period after start
  assign tick = run && (count_q + ETAC_CNT_ONE >= limit);
endmodule
`default_nettype wire

//--- rtl/etac_acq_ctrl.sv
// Acquisition control sequencer: arming, trigger selection, exposure
//
// Operation
// - No frame is captured before an arm command; earlier triggers do nothing.
// - Continuous mode only; arming persists across any number of frames.
// - After disarm takes effect, capture is refused until re-armed.
// - Accepted trigger while waiting leaves waiting, starts exposure then readout.
// - Return to waiting as soon as a new trigger can be accepted.
// - Trigger mode off makes every trigger internally.
// - Free-run trigger rate follows the programmed frame period.
// - Trigger mode on starts one exposure per trigger from selected source.
// - Triggers arriving outside the waiting state are discarded.
// - Source select picks one of five: software, user bit, link, timer, line.
// - Each software trigger command gives one exposure start trigger.
// - User output bit transitions act as trigger events.
// - Each valid link trigger message is one exposure start trigger.
// - Timer source uses the timer active output as trigger.
// - Each valid pulse on the external line is one trigger.
// - Programmed exposure time used for software source or timed mode.
// - Width mode times exposure from the selected signal's rise and fall.
// - Disarm while idle of frames ends capture ability at once.
// - Disarm during a frame finishes that frame, then stops.
// - Arm command during a running frame is ignored.
// - Each accepted trigger both captures and transmits one frame.
// - Activation setting picks rising or falling edge to start exposure.
// - Free-run rate clamps to the maximum allowed rate.
`timescale 1ns/1ps
`default_nettype none
module etac_acq_ctrl
  import etac_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic trigger_mode_on,
  input wire logic [2:0] trigger_source,
  input wire logic activation_rising,
  input wire logic exposure_width_mode,
  input wire logic software_trigger_cmd,
  input wire logic user_output_bit,
  input wire logic link_trigger_input,
  input wire logic timer_active_output,
  input wire logic external_trigger_line,
  input wire logic [ETAC_CNT_W-1:0] exposure_cycles,
  input wire logic [ETAC_CNT_W-1:0] frame_period_cycles,
  input wire logic [ETAC_CNT_W-1:0] min_frame_period_cycles,
  input wire logic [ETAC_RD_W-1:0] readout_cycles,
  input wire logic [ETAC_CNT_W-1:0] recover_cycles,
  output logic armed,
  output logic waiting_for_trigger,
  output logic exposing,
  output logic reading_out,
  output logic frame_start,
  output logic frame_transmit,
  output logic frame_done,
  output logic trigger_discarded,
  output logic arm_ignored
);
  etac_state_t state_q;
  etac_state_t state_d;
  logic armed_q;
  logic stop_pend_q;
  logic width_q;
  logic [ETAC_CNT_W-1:0] cnt_q;
  logic [ETAC_CNT_W-1:0] cnt_d;
  logic frame_start_q;
  logic frame_transmit_q;
  logic frame_done_q;
  logic discard_q;
  logic arm_ign_q;

  logic uo_lvl, uo_rise, uo_fall;
  logic lk_lvl, lk_rise, lk_fall;
  logic tm_lvl, tm_rise, tm_fall;
  logic ln_lvl, ln_rise, ln_fall;
  logic free_tick;
  logic sel_start;
  logic sel_end;
  logic sel_idle;
  logic trig_event;
  logic can_take;
  logic accept;
  logic busy;
  logic use_width;

  // Pick the start edge of a signal per activation setting
  function automatic logic start_edge(input logic r, input logic f,
                                      input logic act_rise);
    start_edge = act_rise ? r : f;
  endfunction

  // Pick the closing edge, the opposite of the start edge
  function automatic logic end_edge(input logic r, input logic f,
                                    input logic act_rise);
    end_edge = act_rise ? f : r;
  endfunction

  // Selected line back at its resting level, opposite the start level
  function automatic logic at_rest(input logic lvl, input logic act_rise);
    at_rest = (lvl != act_rise);
  endfunction

  // Synchronisers for every outside trigger source
  etac_edge_sync u_sync_user (
    .clock(clock),
    .rst(rst),
    .async_in(user_output_bit),
    .level(uo_lvl),
    .rise(uo_rise),
    .fall(uo_fall)
  );
  etac_edge_sync u_sync_link (
    .clock(clock),
    .rst(rst),
    .async_in(link_trigger_input),
    .level(lk_lvl),
    .rise(lk_rise),
    .fall(lk_fall)
  );
  etac_edge_sync u_sync_timer (
    .clock(clock),
    .rst(rst),
    .async_in(timer_active_output),
    .level(tm_lvl),
    .rise(tm_rise),
    .fall(tm_fall)
  );
  etac_edge_sync u_sync_line (
    .clock(clock),
    .rst(rst),
    .async_in(external_trigger_line),
    .level(ln_lvl),
    .rise(ln_rise),
    .fall(ln_fall)
  );

  // Internal free-run trigger generator
  etac_period_timer u_free_run (
    .clock(clock),
    .rst(rst),
    .run(armed_q && !trigger_mode_on),
    .period_cycles(frame_period_cycles),
    .min_period_cycles(min_frame_period_cycles),
    .tick(free_tick)
  );

  // Source multiplexer; only the selected source is looked at
  always_comb
  begin
    sel_start = 1'b0;
    sel_end = 1'b0;
    sel_idle = 1'b1;
    unique case (trigger_source)
      ETAC_SRC_SOFTWARE:
      begin
        sel_start = software_trigger_cmd;
      end
      ETAC_SRC_USER_OUT:
      begin
        sel_start = start_edge(uo_rise, uo_fall, activation_rising);
        sel_end = end_edge(uo_rise, uo_fall, activation_rising);
        sel_idle = at_rest(uo_lvl, activation_rising);
      end
      ETAC_SRC_LINK:
      begin
        sel_start = start_edge(lk_rise, lk_fall, activation_rising);
        sel_end = end_edge(lk_rise, lk_fall, activation_rising);
        sel_idle = at_rest(lk_lvl, activation_rising);
      end
      ETAC_SRC_TIMER:
      begin
        sel_start = start_edge(tm_rise, tm_fall, activation_rising);
        sel_end = end_edge(tm_rise, tm_fall, activation_rising);
        sel_idle = at_rest(tm_lvl, activation_rising);
      end
      ETAC_SRC_LINE:
      begin
        sel_start = start_edge(ln_rise, ln_fall, activation_rising);
        sel_end = end_edge(ln_rise, ln_fall, activation_rising);
        sel_idle = at_rest(ln_lvl, activation_rising);
      end
      default:
      begin
        sel_start = 1'b0;
        sel_end = 1'b0;
        sel_idle = 1'b1;
      end
    endcase
  end

  // Trigger event from internal or selected outside source
  assign trig_event = trigger_mode_on ? sel_start : free_tick;
  // Taken only in waiting while armed; a disarm in the same cycle wins
  assign can_take = (state_q == ETAC_WAIT) && armed_q && !disarm_cmd;
  assign accept = trig_event && can_take;
  assign busy = (state_q == ETAC_EXPOSE) || (state_q == ETAC_READOUT) ||
    (state_q == ETAC_RECOVER);
  // Width mode only with trigger mode on and a non-software source
  assign use_width = trigger_mode_on && exposure_width_mode &&
    (trigger_source != ETAC_SRC_SOFTWARE);

  // Arm flag: arm while no frame runs, disarm now or after frame
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      armed_q <= 1'b0;
    else if (disarm_cmd && !busy)
      armed_q <= 1'b0;
    else if ((stop_pend_q || disarm_cmd) && state_d == ETAC_IDLE)
      armed_q <= 1'b0;
    else if (arm_cmd && !busy && !disarm_cmd)
      armed_q <= 1'b1;
  end

  // Pending disarm held until the running frame completes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stop_pend_q <= 1'b0;
    else if (state_d == ETAC_IDLE)
      stop_pend_q <= 1'b0;
    else if (disarm_cmd && busy)
      stop_pend_q <= 1'b1;
  end

  // Latch exposure style at trigger acceptance
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      width_q <= 1'b0;
    else if (accept)
      width_q <= use_width;
  end

  // Next state and phase counter
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ETAC_IDLE:
      begin
        cnt_d = ETAC_CNT_ZERO;
        if (armed_q && !disarm_cmd)
          state_d = ETAC_WAIT;
      end
      ETAC_WAIT:
      begin
        cnt_d = ETAC_CNT_ZERO;
        if (disarm_cmd || !armed_q)
          state_d = ETAC_IDLE;
        else if (accept)
          state_d = ETAC_EXPOSE;
      end
      ETAC_EXPOSE:
      begin
        cnt_d = cnt_q + ETAC_CNT_ONE;
        // Width mode ends on the closing edge or once the line is at rest
        if (width_q ? (sel_end || sel_idle) :
            (cnt_d >= exposure_cycles))
        begin
          state_d = ETAC_READOUT;
          cnt_d = ETAC_CNT_ZERO;
        end
      end
      ETAC_READOUT:
      begin
        cnt_d = cnt_q + ETAC_CNT_ONE;
        if (cnt_d >= readout_cycles)
        begin
          state_d = ETAC_RECOVER;
          cnt_d = ETAC_CNT_ZERO;
        end
      end
      ETAC_RECOVER:
      begin
        cnt_d = cnt_q + ETAC_CNT_ONE;
        if (cnt_d >= recover_cycles)
        begin
          cnt_d = ETAC_CNT_ZERO;
          if (stop_pend_q || disarm_cmd)
            state_d = ETAC_IDLE;
          else
            state_d = ETAC_WAIT;
        end
      end
      // Codes outside the enum drop back to idle
      default:
      begin
        state_d = ETAC_IDLE;
        cnt_d = ETAC_CNT_ZERO;
      end
    endcase
  end

  // State and counter registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ETAC_IDLE;
      cnt_q <= ETAC_CNT_ZERO;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Frame event pulses and refusal indications
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      frame_start_q <= 1'b0;
      frame_transmit_q <= 1'b0;
      frame_done_q <= 1'b0;
      discard_q <= 1'b0;
      arm_ign_q <= 1'b0;
    end
    else
    begin
      frame_start_q <= accept;
      frame_transmit_q <= (state_q == ETAC_EXPOSE) &&
        (state_d == ETAC_READOUT);
      frame_done_q <= (state_q == ETAC_RECOVER) &&
        (state_d != ETAC_RECOVER);
      discard_q <= trig_event && !accept;
      arm_ign_q <= arm_cmd && busy;
    end
  end

  // Status outputs
  assign armed = armed_q;
  assign waiting_for_trigger = (state_q == ETAC_WAIT);
  assign exposing = (state_q == ETAC_EXPOSE);
  assign reading_out = (state_q == ETAC_READOUT);
  assign frame_start = frame_start_q;
  assign frame_transmit = frame_transmit_q;
  assign frame_done = frame_done_q;
  assign trigger_discarded = discard_q;
  assign arm_ignored = arm_ign_q;
endmodule
`default_nettype wire

//--- sim/etac_trig_partner.sv
// Far-side model: host output bit, link trigger and external lines
`timescale 1ns/1ps
`default_nettype none
module etac_trig_partner
(
  input wire logic clock,
  input wire logic rst,
  input wire logic fire,
  input wire logic [1:0] sel,
  input wire logic [7:0] hold,
  output logic user_output_bit,
  output logic link_trigger_input,
  output logic timer_active_output,
  output logic external_trigger_line
);
  logic [7:0] cnt_q;
  logic [3:0] pin_q;
  // One pulse of hold cycles on the chosen line; a busy line refuses fire
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      cnt_q <= 8'h00;
      pin_q <= 4'h0;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01)
        pin_q <= 4'h0;
    end
    else if (fire)
    begin
      cnt_q <= hold;
      pin_q <= 4'h1 << sel;
    end
  // Lines idle low between pulses
  assign {external_trigger_line, timer_active_output, link_trigger_input,
    user_output_bit} = pin_q;
endmodule
`default_nettype wire

//--- sim/etac_acq_ctrl_asserts.sv
// Port-level checks for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module etac_acq_ctrl_asserts
  import etac_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic trigger_mode_on,
  input wire logic [2:0] trigger_source,
  input wire logic exposure_width_mode,
  input wire logic software_trigger_cmd,
  input wire logic [ETAC_CNT_W-1:0] exposure_cycles,
  input wire logic armed,
  input wire logic waiting_for_trigger,
  input wire logic exposing,
  input wire logic reading_out,
  input wire logic frame_start,
  input wire logic frame_transmit,
  input wire logic frame_done,
  input wire logic trigger_discarded,
  input wire logic arm_ignored
);
  logic [ETAC_CNT_W-1:0] len_q;
  // Decoded trigger conditions and the expected timed length
  wire sw_go = software_trigger_cmd && trigger_mode_on
    && trigger_source == ETAC_SRC_SOFTWARE;
  wire timed = !trigger_mode_on || !exposure_width_mode
    || trigger_source == ETAC_SRC_SOFTWARE;
  wire [ETAC_CNT_W-1:0] len_exp = (exposure_cycles == ETAC_CNT_ZERO)
    ? ETAC_CNT_ONE : exposure_cycles;
  // Length of the exposure in progress
  always_ff @(posedge clock or posedge rst)
    if (rst)
      len_q <= ETAC_CNT_ZERO;
    else
      len_q <= exposing ? len_q + ETAC_CNT_ONE : ETAC_CNT_ZERO;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Arm request that may be taken, then armed and waiting
  sequence s_arm_req;
    arm_cmd && !disarm_cmd && !armed && !exposing && !reading_out;
  endsequence
  sequence s_arm_done;
    armed ##1 (armed && waiting_for_trigger);
  endsequence
  a_arm_then_wait: assert property (s_arm_req |=> s_arm_done)
    else $error("arm did not lead to waiting");
  a_start_from_wait: assert property (
    frame_start |-> $past(waiting_for_trigger) && exposing
    && !waiting_for_trigger) else $error("start without waiting");
  a_sw_accept: assert property (
    waiting_for_trigger && sw_go && !disarm_cmd |=> frame_start)
    else $error("software trigger not taken");
  a_sw_discard: assert property (
    sw_go && !waiting_for_trigger |=> trigger_discarded && !frame_start)
    else $error("stray trigger not discarded");
  a_timed_len: assert property (
    $fell(exposing) && timed |-> len_q == len_exp)
    else $error("exposure length wrong");
  a_readout_next: assert property (
    $fell(exposing) |-> reading_out && frame_transmit)
    else $error("no readout after exposure");
  a_arm_busy: assert property (
    arm_cmd && !disarm_cmd && (exposing || reading_out) |=> arm_ignored)
    else $error("busy arm not flagged");
  a_disarm_busy: assert property (
    disarm_cmd && (exposing || reading_out) |=> armed [*2])
    else $error("disarm cut a frame short");
  a_stop_at_end: assert property (
    frame_done && $past(disarm_cmd) |-> !armed)
    else $error("late disarm left the sequencer armed");
  a_wait_armed: assert property (
    waiting_for_trigger |-> armed)
    else $error("waiting while not armed");
endmodule
`default_nettype wire

//--- sim/test_etac_acq_ctrl.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module test_etac_acq_ctrl
  import etac_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] cmd = 4'h0;
  logic trigger_mode_on = 1'b1;
  logic [2:0] trigger_source = ETAC_SRC_SOFTWARE;
  logic activation_rising = 1'b1;
  logic exposure_width_mode = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] hold = 8'h06;
  logic [ETAC_CNT_W-1:0] exposure_cycles = 24'h00_0003;
  logic [ETAC_CNT_W-1:0] frame_period_cycles = 24'h00_0032;
  logic [ETAC_CNT_W-1:0] min_frame_period_cycles = 24'h00_0014;
  logic [ETAC_RD_W-1:0] readout_cycles = 24'h00_0004;
  logic [ETAC_CNT_W-1:0] recover_cycles = 24'h00_0002;
  wire user_output_bit, link_trigger_input;
  wire timer_active_output, external_trigger_line;
  wire armed, waiting_for_trigger, exposing, reading_out, frame_start;
  wire frame_transmit, frame_done, trigger_discarded, arm_ignored;
  wire [4:0] fl = {~armed, frame_done, frame_start, waiting_for_trigger,
    armed};
  int errors = 0;
  int num_checks = 0;
  int fs = 0;
  int tx = 0;
  int dsc = 0;
  int ign = 0;
  int exp_n = 0;
  // 50 MHz clock
  always #10 clock = ~clock;
  etac_acq_ctrl u_dut (.clock, .rst, .arm_cmd(cmd[0]), .disarm_cmd(cmd[1]),
    .trigger_mode_on, .trigger_source, .activation_rising,
    .exposure_width_mode, .software_trigger_cmd(cmd[2]), .user_output_bit,
    .link_trigger_input, .timer_active_output, .external_trigger_line,
    .exposure_cycles, .frame_period_cycles, .min_frame_period_cycles,
    .readout_cycles, .recover_cycles, .armed, .waiting_for_trigger,
    .exposing, .reading_out, .frame_start, .frame_transmit, .frame_done,
    .trigger_discarded, .arm_ignored);
  etac_trig_partner u_far (.clock, .rst, .fire(cmd[3]), .sel, .hold,
    .user_output_bit, .link_trigger_input, .timer_active_output,
    .external_trigger_line);
  // Tallies of output pulses and of exposure cycles
  always @(posedge clock)
  begin
    fs += (frame_start === 1'b1);
    tx += (frame_transmit === 1'b1);
    dsc += (trigger_discarded === 1'b1);
    ign += (arm_ignored === 1'b1);
    exp_n += (exposing === 1'b1);
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, want);
    end
  endtask
  // One-cycle command pulse: 0 arm, 1 disarm, 2 software, 3 far side
  task automatic hit(input int k);
    @(posedge clock);
    cmd[k] <= 1'b1;
    @(posedge clock);
    cmd[k] <= 1'b0;
  endtask
  // Bounded wait for a status flag, seen at the falling edge
  task automatic wait_hi(input int k);
    int i = 0;
    @(negedge clock);
    while (fl[k] !== 1'b1 && i < 300)
    begin
      @(negedge clock);
      i++;
    end
    if (i == 300)
    begin
      $display("ERROR %0t got %h exp %h", $time, fl, 5'h01 << k);
      errors++;
      wrap_up();
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    hit(2);
    @(negedge clock);
    chk(trigger_discarded, 1'b1);
    hit(0);
    @(negedge clock);
    chk(armed, 1'b1);
    @(negedge clock);
    chk(waiting_for_trigger, 1'b1);
    repeat (2)
    begin
      exp_n = 0;
      hit(2);
      wait_hi(3);
      chk(exp_n, 3);
      chk(waiting_for_trigger, 1'b1);
    end
    chk(tx, 2);
    chk(fs, 2);
    // Trigger and arm while busy, then disarm in mid-frame
    hit(2);
    hit(2);
    hit(0);
    hit(1);
    wait_hi(3);
    chk(dsc, 2);
    chk(ign, 1);
    @(negedge clock);
    chk(armed, 1'b0);
    hit(2);
    repeat (20) @(negedge clock);
    chk(fs, 3);
    // Each external source, plus a pulse on a line not selected
    for (int s = 1; s < 5; s++)
    begin
      @(posedge clock);
      trigger_source <= 3'(s);
      exposure_width_mode <= (s == 2);
      sel <= 2'(s - 1);
      hit(0);
      wait_hi(1);
      exp_n = 0;
      hit(3);
      wait_hi(3);
      chk(s == 2 ? exp_n > 4 && exp_n < 8 : exp_n == 3, 1);
      sel <= 2'(s % 4);
      hit(3);
      repeat (30) @(negedge clock);
      chk(fs, 3 + s);
      hit(1);
      wait_hi(4);
    end
    // Falling activation: a rise alone starts nothing
    @(posedge clock);
    activation_rising <= 1'b0;
    hold <= 8'h0a;
    sel <= 2'h3;
    hit(0);
    wait_hi(1);
    hit(3);
    repeat (8) @(negedge clock);
    chk(fs, 7);
    wait_hi(3);
    chk(fs, 8);
    hit(1);
    wait_hi(4);
    // Disarm in the last recovery cycle still stops capture
    @(posedge clock);
    trigger_source <= ETAC_SRC_SOFTWARE;
    hit(0);
    wait_hi(1);
    hit(2);
    repeat (7) @(posedge clock);
    hit(1);
    wait_hi(4);
    repeat (3) @(negedge clock);
    chk(waiting_for_trigger, 1'b0);
    // Free run at the programmed period, then clamped to the minimum
    @(posedge clock);
    trigger_mode_on <= 1'b0;
    hit(0);
    fs = 0;
    repeat (500) @(negedge clock);
    chk(fs > 8 && fs < 12, 1);
    hit(1);
    wait_hi(4);
    @(posedge clock);
    frame_period_cycles <= 24'h00_0005;
    min_frame_period_cycles <= 24'h00_001e;
    hit(0);
    fs = 0;
    repeat (600) @(negedge clock);
    chk(fs > 17 && fs < 22, 1);
    wrap_up();
  end
endmodule
bind etac_acq_ctrl etac_acq_ctrl_asserts u_chk (.clock, .rst, .arm_cmd,
  .disarm_cmd, .trigger_mode_on, .trigger_source, .exposure_width_mode,
  .software_trigger_cmd, .exposure_cycles, .armed, .waiting_for_trigger,
  .exposing, .reading_out, .frame_start, .frame_transmit, .frame_done,
  .trigger_discarded, .arm_ignored);
`default_nettype wire
